/* File: design/nct_device.sv */
`include "nct_regs.svh"

module nct_device
	import nct_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	nct_if.dev                            lnk,
	input  wire logic                     cfgWrEn,
	input  wire logic [`NCT_VF_IDX_W-1:0] cfgWrVf,
	input  wire logic [`NCT_MODE_W-1:0]   cfgWrMode,
	input  wire logic                     hdrCreditReturn,
	input  wire logic [`NCT_AV_W-1:0]     payCreditReturn,
	input  wire logic                     tagRelease
);

	// ----------------------------------------
	// Steering mode store
	// ----------------------------------------

	nct_mode_t modeFf  [`NCT_NUM_VF];
	nct_mode_t nxtMode [`NCT_NUM_VF];

	// Write one function's mode; out-of-range index is dropped
	always_comb begin
		for (int i = 0; i < `NCT_NUM_VF; i++) begin
			nxtMode[i] = modeFf[i];
		end
		if (cfgWrEn && (cfgWrVf < `NCT_VF_IDX_W'(`NCT_NUM_VF))) begin
			nxtMode[cfgWrVf] = cfgWrMode;
		end
	end

	// Per-function register and output slice
	genvar v;
	generate
		for (v = 0; v < `NCT_NUM_VF; v++) begin : g_vf
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					modeFf[v] <= '0;
				end else begin
					modeFf[v] <= nxtMode[v];
				end
			end
			// Function v sits at bits 3v+2..3v
			assign lnk.vfSteeringModeOut[v*`NCT_MODE_W +: `NCT_MODE_W]
				= modeFf[v];
		end
	endgenerate

	// ----------------------------------------
	// Credit and tag pools
	// ----------------------------------------

	nct_cnt_t hdrFf;
	nct_cnt_t payFf;
	nct_cnt_t tagFf;
	logic     takenFf;
	nct_cnt_t nxtHdr;
	nct_cnt_t nxtPay;
	nct_cnt_t nxtTag;
	logic     nxtTaken;
	logic     take;
	nct_cnt_t needPay;

	// Accept only with a header, a tag and enough payload;
	// takenFf blocks a second take of the same held request
	always_comb begin
		needPay  = nct_cnt_t'(lnk.npReqPayload);
		take     = lnk.npReqValid && !takenFf
			&& (hdrFf != `NCT_CNT_ZERO)
			&& (tagFf != `NCT_CNT_ZERO)
			&& (payFf >= needPay);
		nxtTaken = take;
		nxtHdr   = hdrFf;
		nxtPay   = payFf;
		nxtTag   = tagFf;
		if (take) begin
			nxtHdr = nxtHdr - `NCT_CNT_ONE;
			nxtPay = nxtPay - needPay;
			nxtTag = nxtTag - `NCT_CNT_ONE;
		end
		// Returns clamp at pool size so a stray return cannot inflate
		if (hdrCreditReturn && (nxtHdr < `NCT_HDR_INIT)) begin
			nxtHdr = nxtHdr + `NCT_CNT_ONE;
		end
		if (nxtPay + nct_cnt_t'(payCreditReturn) > `NCT_PAY_INIT) begin
			nxtPay = `NCT_PAY_INIT;
		end else begin
			nxtPay = nxtPay + nct_cnt_t'(payCreditReturn);
		end
		if (tagRelease && (nxtTag < `NCT_TAG_INIT)) begin
			nxtTag = nxtTag + `NCT_CNT_ONE;
		end
	end

	// Pool registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdrFf   <= `NCT_HDR_INIT;
			payFf   <= `NCT_PAY_INIT;
			tagFf   <= `NCT_TAG_INIT;
			takenFf <= 1'b0;
		end else begin
			hdrFf   <= nxtHdr;
			payFf   <= nxtPay;
			tagFf   <= nxtTag;
			takenFf <= nxtTaken;
		end
	end

	assign lnk.npReqTaken = takenFf;

	// ----------------------------------------
	// Report pipeline
	// ----------------------------------------

	// Mimics the core's pipeline: the report trails the pools by
	// six cycles, inside the eight the user must correct for
	nct_av_s stageFf  [`NCT_LAG_STAGES];
	nct_av_s nxtStage [`NCT_LAG_STAGES];

	// Saturate at the head, plain shift behind it
	always_comb begin
		nxtStage[0].hdr = nctSat(hdrFf);
		nxtStage[0].pay = nctSat(payFf);
		nxtStage[0].tag = nctSat(tagFf);
		for (int s = 1; s < `NCT_LAG_STAGES; s++) begin
			nxtStage[s] = stageFf[s-1];
		end
	end

	// Stage registers, reset to the full-pool report
	genvar g;
	generate
		for (g = 0; g < `NCT_LAG_STAGES; g++) begin : g_lag
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					stageFf[g].hdr <= nctSat(`NCT_HDR_INIT);
					stageFf[g].pay <= nctSat(`NCT_PAY_INIT);
					stageFf[g].tag <= nctSat(`NCT_TAG_INIT);
				end else begin
					stageFf[g] <= nxtStage[g];
				end
			end
		end
	endgenerate

	// Outputs are the last stage flops
	assign lnk.npHeaderCreditAvail  = stageFf[`NCT_LAG_STAGES-1].hdr;
	assign lnk.npPayloadCreditAvail = stageFf[`NCT_LAG_STAGES-1].pay;
	assign lnk.freeRequestTagCount  = stageFf[`NCT_LAG_STAGES-1].tag;

endmodule : nct_device

/* File: pkg/nct_regs.svh */
// Operation
// - Steering mode output, three bits per function.
// - Header credit count saturates at fifteen.
// - Header count may lag up to eight cycles.
// - User subtracts its recent header credit use.
// - User checks header credit before issuing.
// - Payload credit count, top code means at-least.
// - Payload count may lag up to eight cycles.
// - User checks and deducts recent payload use.
// - Free tag count saturates at fifteen.
// - Tag count may lag up to eight cycles.
// - User checks tags, subtracts one per request.
`ifndef NCT_REGS_SVH
`define NCT_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NCT_NUM_VF      252
`define NCT_MODE_W      3
`define NCT_MODE_BITS   756
`define NCT_VF_IDX_W    8
`define NCT_AV_W        4
`define NCT_CNT_W       12

// ----------------------------------------
// Count limits and pool sizes
// ----------------------------------------
`define NCT_AV_MAX      12'h00f
`define NCT_HDR_INIT    12'h020
`define NCT_PAY_INIT    12'h080
`define NCT_TAG_INIT    12'h040
`define NCT_CNT_ZERO    12'h000
`define NCT_CNT_ONE     12'h001

// ----------------------------------------
// Reporting lag
// ----------------------------------------
`define NCT_LAG_STAGES  6
`define NCT_HIST_DEPTH  8

`endif

/* File: pkg/nct_pkg.sv */
`include "nct_regs.svh"

package nct_pkg;

	typedef logic [`NCT_CNT_W-1:0] nct_cnt_t;
	typedef logic [`NCT_AV_W-1:0]  nct_av_t;
	typedef logic [`NCT_MODE_W-1:0] nct_mode_t;

	// Reported triple carried down the lag pipeline
	typedef struct packed {
		nct_av_t hdr;
		nct_av_t pay;
		nct_av_t tag;
	} nct_av_s;

	typedef enum logic [1:0] {
		NCT_IDLE  = 2'h1,
		NCT_ISSUE = 2'h2
	} nct_state_e;

	// Clamp a pool count to the four-bit report code
	function automatic nct_av_t nctSat(input nct_cnt_t c);
		nctSat = (c >= `NCT_AV_MAX) ? nct_av_t'(`NCT_AV_MAX)
			: c[`NCT_AV_W-1:0];
	endfunction : nctSat

endpackage : nct_pkg

/* File: pkg/nct_if.sv */
`include "nct_regs.svh"

interface nct_if;
	logic                      npReqValid;
	logic [`NCT_AV_W-1:0]      npReqPayload;
	logic                      npReqTaken;
	logic [`NCT_AV_W-1:0]      npHeaderCreditAvail;
	logic [`NCT_AV_W-1:0]      npPayloadCreditAvail;
	logic [`NCT_AV_W-1:0]      freeRequestTagCount;
	logic [`NCT_MODE_BITS-1:0] vfSteeringModeOut;

	modport dev (
		input  npReqValid,
		input  npReqPayload,
		output npReqTaken,
		output npHeaderCreditAvail,
		output npPayloadCreditAvail,
		output freeRequestTagCount,
		output vfSteeringModeOut
	);

	modport usr (
		output npReqValid,
		output npReqPayload,
		input  npReqTaken,
		input  npHeaderCreditAvail,
		input  npPayloadCreditAvail,
		input  freeRequestTagCount,
		input  vfSteeringModeOut
	);
endinterface : nct_if

/* File: design/nct_user.sv */
`include "nct_regs.svh"

module nct_user
	import nct_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	nct_if.usr                        lnk,
	input  wire logic                 userReqValid,
	input  wire logic [`NCT_AV_W-1:0] userReqPayload,
	output logic                      userReqDone,
	output logic                      userBusy
);

	// ----------------------------------------
	// Recent issue history
	// ----------------------------------------

	logic    histFf     [`NCT_HIST_DEPTH];
	nct_av_t histPayFf  [`NCT_HIST_DEPTH];
	logic    nxtHist    [`NCT_HIST_DEPTH];
	nct_av_t nxtHistPay [`NCT_HIST_DEPTH];
	nct_cnt_t recentCnt;
	nct_cnt_t recentPay;

	// Every take stays counted for eight cycles; may double count
	// against an already updated report, which is safe
	always_comb begin
		nxtHist[0]    = lnk.npReqTaken;
		nxtHistPay[0] = lnk.npReqTaken ? lnk.npReqPayload : '0;
		for (int h = 1; h < `NCT_HIST_DEPTH; h++) begin
			nxtHist[h]    = histFf[h-1];
			nxtHistPay[h] = histPayFf[h-1];
		end
		recentCnt = `NCT_CNT_ZERO;
		recentPay = `NCT_CNT_ZERO;
		for (int h = 0; h < `NCT_HIST_DEPTH; h++) begin
			recentCnt = recentCnt + nct_cnt_t'(histFf[h]);
			recentPay = recentPay + nct_cnt_t'(histPayFf[h]);
		end
	end

	// History registers
	genvar g;
	generate
		for (g = 0; g < `NCT_HIST_DEPTH; g++) begin : g_hist
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					histFf[g]    <= 1'b0;
					histPayFf[g] <= '0;
				end else begin
					histFf[g]    <= nxtHist[g];
					histPayFf[g] <= nxtHistPay[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Issue control
	// ----------------------------------------

	nct_state_e stateFf;
	nct_state_e nxtState;
	logic       validFf;
	nct_av_t    payFf;
	logic       doneFf;
	logic       nxtValid;
	nct_av_t    nxtPay;
	logic       nxtDone;
	logic       roomOk;
	nct_cnt_t   hdrRep;
	nct_cnt_t   payRep;
	nct_cnt_t   tagRep;

	// Corrected counts; the outstanding request counts as used
	always_comb begin
		hdrRep = nct_cnt_t'(lnk.npHeaderCreditAvail);
		payRep = nct_cnt_t'(lnk.npPayloadCreditAvail);
		tagRep = nct_cnt_t'(lnk.freeRequestTagCount);
		roomOk = (hdrRep > recentCnt)
			&& (tagRep > recentCnt)
			&& (payRep >= recentPay + nct_cnt_t'(userReqPayload));
		nxtState = stateFf;
		nxtValid = validFf;
		nxtPay   = payFf;
		nxtDone  = 1'b0;
		case (stateFf)
			NCT_IDLE: begin
				// Hold back until corrected header and tag counts are positive and corrected payload covers the request
				if (userReqValid && roomOk) begin
					nxtValid = 1'b1;
					nxtPay   = userReqPayload;
					nxtState = NCT_ISSUE;
				end
			end
			NCT_ISSUE: begin
				if (lnk.npReqTaken) begin
					nxtValid = 1'b0;
					nxtDone  = 1'b1;
					nxtState = NCT_IDLE;
				end
			end
			default: begin
				nxtValid = 1'b0;
				nxtState = NCT_IDLE;
			end
		endcase
	end

	// Control registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stateFf <= NCT_IDLE;
			validFf <= 1'b0;
			payFf   <= '0;
			doneFf  <= 1'b0;
		end else begin
			stateFf <= nxtState;
			validFf <= nxtValid;
			payFf   <= nxtPay;
			doneFf  <= nxtDone;
		end
	end

	assign lnk.npReqValid   = validFf;
	assign lnk.npReqPayload = payFf;
	assign userReqDone      = doneFf;
	assign userBusy         = validFf;

endmodule : nct_user

/* File: bench/nct_link_monitor.sv */
`include "nct_regs.svh"

module nct_link_monitor (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire logic                 npReqValid,
	input wire logic [`NCT_AV_W-1:0] npReqPayload,
	input wire logic                 npReqTaken,
	input wire logic [`NCT_AV_W-1:0] npHeaderCreditAvail,
	input wire logic [`NCT_AV_W-1:0] npPayloadCreditAvail,
	input wire logic [`NCT_AV_W-1:0] freeRequestTagCount
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] sinceTake_ff;
	logic [3:0] nxt_sinceTake;

	// ----
	// Age of the last take, saturating so it never wraps
	// ----
	always_comb begin
		nxt_sinceTake = sinceTake_ff;
		if (sys_rst || sinceTake_ff == 4'hf)
			nxt_sinceTake = 4'hf;
		if (!sys_rst && sinceTake_ff != 4'hf)
			nxt_sinceTake = sinceTake_ff + 4'h1;
		if (!sys_rst && npReqTaken)
			nxt_sinceTake = 4'h0;
	end

	always_ff @(posedge clk) begin
		sinceTake_ff <= nxt_sinceTake;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Reports may only fall shortly after a take
	hdr_lag_a: assert property (
		npHeaderCreditAvail < $past(npHeaderCreditAvail)
		|-> sinceTake_ff <= 4'h8) else $error("header fell, no take");
	pay_lag_a: assert property (
		npPayloadCreditAvail < $past(npPayloadCreditAvail)
		|-> sinceTake_ff <= 4'h8) else $error("payload fell, no take");
	tag_lag_a: assert property (
		freeRequestTagCount < $past(freeRequestTagCount)
		|-> sinceTake_ff <= 4'h8) else $error("tags fell, no take");
	// New requests only while the reports show room
	hdr_gate_a: assert property (
		$rose(npReqValid) |-> $past(npHeaderCreditAvail) != 4'h0)
		else $error("request with no header credit");
	pay_gate_a: assert property (
		$rose(npReqValid) |-> $past(npPayloadCreditAvail) >= npReqPayload)
		else $error("request with short payload credit");
	tag_gate_a: assert property (
		$rose(npReqValid) |-> $past(freeRequestTagCount) != 4'h0)
		else $error("request with no free tag");
	// Handshake shape
	take_pulse_a: assert property (npReqTaken |=> !npReqTaken)
		else $error("take longer than one cycle");
	take_valid_a: assert property (npReqTaken |-> $past(npReqValid))
		else $error("take without request");
	req_hold_a: assert property (
		npReqValid && !npReqTaken |=> npReqValid && $stable(npReqPayload))
		else $error("request dropped before take");
endmodule : nct_link_monitor

/* File: bench/test_nonposted_credit_tag_status.sv */
`include "nct_regs.svh"

module test_nonposted_credit_tag_status;
	timeunit 1ns;
	timeprecision 100ps;

	logic                     clk = 1'b0;
	logic                     sys_rst = 1'b1;
	logic                     cfgWrEn = 1'b0;
	logic [`NCT_VF_IDX_W-1:0] cfgWrVf = 8'h00;
	logic [`NCT_MODE_W-1:0]   cfgWrMode = 3'h0;
	logic                     hdrCreditReturn = 1'b0;
	logic [`NCT_AV_W-1:0]     payCreditReturn = 4'h0;
	logic                     tagRelease = 1'b0;
	logic                     userReqValid = 1'b0;
	logic [`NCT_AV_W-1:0]     userReqPayload = 4'h0;
	logic                     userReqDone;
	logic                     userBusy;
	int                       miscompares = 0;
	int                       checks = 0;

	nct_if lnkIf ();

	// Free-running system clock
	always #2 clk = ~clk;

	nct_device i_nct_device (.clk(clk), .sys_rst(sys_rst), .lnk(lnkIf),
		.cfgWrEn(cfgWrEn), .cfgWrVf(cfgWrVf), .cfgWrMode(cfgWrMode),
		.hdrCreditReturn(hdrCreditReturn), .payCreditReturn(payCreditReturn),
		.tagRelease(tagRelease));
	nct_user i_nct_user (.clk(clk), .sys_rst(sys_rst), .lnk(lnkIf),
		.userReqValid(userReqValid), .userReqPayload(userReqPayload),
		.userReqDone(userReqDone), .userBusy(userBusy));
	nct_link_monitor i_nct_link_monitor (.clk(clk), .sys_rst(sys_rst),
		.npReqValid(lnkIf.npReqValid), .npReqPayload(lnkIf.npReqPayload),
		.npReqTaken(lnkIf.npReqTaken),
		.npHeaderCreditAvail(lnkIf.npHeaderCreditAvail),
		.npPayloadCreditAvail(lnkIf.npPayloadCreditAvail),
		.freeRequestTagCount(lnkIf.freeRequestTagCount));

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// A refused request returns with the request still held;
	// an expected one that never issues or completes ends the run
	task automatic req(input logic [3:0] p, input int lim,
		input logic expOk);
		int n;
		userReqPayload <= p;
		userReqValid <= 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (userBusy !== 1'b1 && n < lim);
		if (!expOk) begin
			return;
		end
		if (userBusy !== 1'b1) begin
			chk({3'h0, userBusy}, 4'h1);
			end_sim();
		end else begin
			userReqValid <= 1'b0;
			n = 0;
			do begin
				tick(1);
				n++;
			end while (userReqDone !== 1'b1 && n < 40);
			chk({3'h0, userReqDone}, 4'h1);
			if (userReqDone !== 1'b1) begin
				end_sim();
			end
		end
	endtask : req

	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// ----
	// Main sequence
	// ----
	initial begin : mainSeq
		logic [7:0] vfTab [4];
		logic [2:0] mdTab [4];
		vfTab = '{8'h00, 8'h01, 8'hfb, 8'hfc};
		mdTab = '{3'h5, 3'h3, 3'h7, 3'h6};
		tick(8);
		sys_rst <= 1'b0;
		tick(2);
		chk(lnkIf.npHeaderCreditAvail, 4'hf);
		chk(lnkIf.npPayloadCreditAvail, 4'hf);
		chk(lnkIf.freeRequestTagCount, 4'hf);
		$display("test reset done");
		// Back to back writes; the last index is out of range
		for (int i = 0; i < 4; i++) begin
			cfgWrEn <= 1'b1;
			cfgWrVf <= vfTab[i];
			cfgWrMode <= mdTab[i];
			tick(1);
		end
		cfgWrEn <= 1'b0;
		tick(3);
		chk({1'b0, lnkIf.vfSteeringModeOut[2:0]}, 4'h5);
		chk({1'b0, lnkIf.vfSteeringModeOut[5:3]}, 4'h3);
		chk({1'b0, lnkIf.vfSteeringModeOut[755:753]}, 4'h7);
		chk({1'b0, lnkIf.vfSteeringModeOut[752:750]}, 4'h0);
		$display("test steering done");
		// Headers kept topped up, so only tags drain to 14
		hdrCreditReturn <= 1'b1;
		repeat (50) req(4'h0, 40, 1'b1);
		tick(12);
		chk(lnkIf.freeRequestTagCount, 4'he);
		chk(lnkIf.npHeaderCreditAvail, 4'hf);
		hdrCreditReturn <= 1'b0;
		tagRelease <= 1'b1;
		$display("test tags done");
		// Drain header and payload pools to exactly zero
		repeat (32) req(4'h4, 40, 1'b1);
		tagRelease <= 1'b0;
		tick(12);
		chk(lnkIf.npHeaderCreditAvail, 4'h0);
		chk(lnkIf.npPayloadCreditAvail, 4'h0);
		chk(lnkIf.freeRequestTagCount, 4'hf);
		$display("test drain done");
		req(4'h1, 30, 1'b0);
		chk({3'h0, userBusy}, 4'h0);
		hdrCreditReturn <= 1'b1;
		tick(1);
		hdrCreditReturn <= 1'b0;
		tick(12);
		chk(lnkIf.npHeaderCreditAvail, 4'h1);
		chk({3'h0, userBusy}, 4'h0);
		payCreditReturn <= 4'h2;
		tick(1);
		payCreditReturn <= 4'h0;
		req(4'h1, 40, 1'b1);
		tick(12);
		chk(lnkIf.npPayloadCreditAvail, 4'h1);
		chk(lnkIf.npHeaderCreditAvail, 4'h0);
		$display("test stall done");
		end_sim();
	end
endmodule : test_nonposted_credit_tag_status
